// File: shared/dcd_pkg.sv
// Package for the channel record decoder: offsets, field layout, encodings.
// Assumes a single clock domain and a 32-bit APB register port.
package dcd_pkg;

  // APB byte addresses of the block's own registers
  localparam logic [11:0] DCD_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] DCD_BASE0_ADDR  = 12'h004;
  localparam logic [11:0] DCD_BASE1_ADDR  = 12'h008;
  localparam logic [11:0] DCD_STATUS_ADDR = 12'h00C;
  localparam logic [11:0] DCD_RECLO_ADDR  = 12'h010;
  localparam logic [11:0] DCD_RECHI_ADDR  = 12'h014;
  localparam logic [11:0] DCD_COUNT_ADDR  = 12'h018;

  // Control register fields
  localparam int DCD_CTRL_START_BIT = 0;
  localparam int DCD_CTRL_CHAN_LSB  = 2;
  localparam int DCD_CTRL_CHAN_MSB  = 4;

  // Reset values
  localparam logic [15:0] DCD_BASE_RESET = 16'h0000;
  localparam logic [2:0]  DCD_CHAN_RESET = 3'h0;

  // Record geometry
  localparam int          DCD_RECORD_BYTES = 8;
  localparam logic [2:0]  DCD_LAST_CHANNEL = 3'h4;
  localparam logic [2:0]  DCD_LAST_BYTE    = 3'h7;

  // Variable-length selector codes
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_FIXED    = 3'h0;
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_PLUS1    = 3'h1;
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_EXACT    = 3'h2;
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_PLUS2    = 3'h3;
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_PLUS3    = 3'h4;
  localparam logic [2:0] DCD_VARIABLE_LENGTH_SELECTOR_FIXED_B  = 3'h7;

  // Trigger codes
  localparam logic [4:0] DCD_TRIGGER_SELECT_SOFTWARE = 5'h00;
  localparam logic [4:0] DCD_TRIGGER_SELECT_PREVIOUS = 5'h01;
  localparam logic [4:0] DCD_TRIGGER_SELECT_PERIPH_LO = 5'h02;
  localparam logic [4:0] DCD_TRIGGER_SELECT_PERIPH_HI = 5'h1E;
  localparam int         DCD_PERIPH_EVENTS  = 29;

  // Address step codes
  localparam logic [1:0] DCD_STEP_NONE  = 2'h0;
  localparam logic [1:0] DCD_STEP_ONE   = 2'h1;
  localparam logic [1:0] DCD_STEP_TWO   = 2'h2;
  localparam logic [1:0] DCD_STEP_MINUS = 2'h3;

  typedef enum logic [1:0]
  {
    DCD_PAT_SINGLE       = 2'b00,
    DCD_PAT_BLOCK        = 2'b01,
    DCD_PAT_REPEAT_SINGLE = 2'b10,
    DCD_PAT_REPEAT_BLOCK  = 2'b11
  } dcd_pattern_t;

  typedef enum logic [1:0]
  {
    DCD_PRI_CPU_FIRST   = 2'b00,
    DCD_PRI_EVERY_OTHER = 2'b01,
    DCD_PRI_DMA_FIRST   = 2'b10,
    DCD_PRI_HIGHEST     = 2'b11
  } dcd_priority_t;

  // Record exactly as it lies in memory, byte 0 in the top bits
  typedef struct packed
  {
    logic [15:0]   source_pointer;
    logic [15:0]   destination_pointer;
    logic [2:0]    variable_length_selector;
    logic [12:0]   fixed_transfer_count;
    logic          item_width_select;
    dcd_pattern_t  transfer_pattern;
    logic [4:0]    trigger_select;
    logic [1:0]    source_step;
    logic [1:0]    destination_step;
    logic          completion_interrupt_enable;
    logic          length_byte_seven_bit_select;
    dcd_priority_t priority_level;
  } dcd_record_t;

endpackage

// File: verilog/dcd_length_calc.sv
// Transfer count from the variable-length selector and the first item.
// Assumes its inputs come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dcd_length_calc
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // First item and record fields
  input  wire logic        first_valid,
  input  wire logic [15:0] first_item,
  input  wire logic [2:0]  variable_length_selector,
  input  wire logic [12:0] fixed_transfer_count,
  input  wire logic        item_width_select,
  input  wire logic        length_byte_seven_bit_select,
  // Result
  output logic      [12:0] effective_count,
  output logic             count_valid
);
  import dcd_pkg::*;

  logic [13:0] first_len;
  logic [13:0] raw_len;
  logic [12:0] next_count;

  always_comb
  begin
    if (item_width_select)
      first_len = {1'b0, first_item[12:0]};
    else if (length_byte_seven_bit_select)
      first_len = {7'h00, first_item[6:0]};
    else
      first_len = {6'h00, first_item[7:0]};
    case (variable_length_selector)
      DCD_VARIABLE_LENGTH_SELECTOR_PLUS1: raw_len = first_len + 14'h0001;
      DCD_VARIABLE_LENGTH_SELECTOR_EXACT: raw_len = first_len;
      DCD_VARIABLE_LENGTH_SELECTOR_PLUS2: raw_len = first_len + 14'h0002;
      DCD_VARIABLE_LENGTH_SELECTOR_PLUS3: raw_len = first_len + 14'h0003;
      default:        raw_len = {1'b0, fixed_transfer_count};
    endcase
    // The fixed count is always the ceiling, so reserved codes fall back to it
    if (raw_len > {1'b0, fixed_transfer_count})
      next_count = fixed_transfer_count;
    else
      next_count = raw_len[12:0];
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      effective_count <= 13'h0000;
      count_valid     <= 1'b0;
    end
    else
    begin
      count_valid <= first_valid;
      if (first_valid)
        effective_count <= next_count;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_count_ceiling: assert property (count_valid
      |-> effective_count <= $past(fixed_transfer_count))
    else $error("count above fixed ceiling");
  a_fixed_select: assert property (first_valid && (variable_length_selector == DCD_VARIABLE_LENGTH_SELECTOR_FIXED
      || variable_length_selector == DCD_VARIABLE_LENGTH_SELECTOR_FIXED_B)
      |=> effective_count == $past(fixed_transfer_count))
    else $error("fixed selector did not use fixed count");
  a_plus_one_len: assert property (first_valid && variable_length_selector == DCD_VARIABLE_LENGTH_SELECTOR_PLUS1
      && item_width_select && {1'b0, first_item[12:0]} < {1'b0, fixed_transfer_count}
      |=> effective_count == $past(first_item[12:0]) + 13'h0001)
    else $error("plus one length wrong in word mode");
  a_seven_bit: assert property (first_valid && variable_length_selector == DCD_VARIABLE_LENGTH_SELECTOR_EXACT
      && !item_width_select && length_byte_seven_bit_select && fixed_transfer_count == 13'h1FFF
      |=> effective_count == {6'h00, $past(first_item[6:0])})
    else $error("seven bit length byte not masked");
  c_word_length: cover property (count_valid && item_width_select);

endmodule // dcd_length_calc
`default_nettype wire

// File: verilog/dcd_top.sv
// Channel record fetch and decode: reads the eight-byte record of a channel
// from memory, decodes it for the channel sequencer, exposes it over APB.
// Assumes a zero-wait APB master and a memory port on the same clock.
// Contract
// - Source pointer is record bytes 0 (high) and 1 (low).
// - Destination pointer is record bytes 2 (high) and 3 (low).
// - Selector 000 or 111 in byte 4 bits 7:5 uses fixed count.
// - Selector 001 moves first item value plus one, capped by fixed count.
// - Selector 010 moves first item value including it, capped.
// - Selectors 011 and 100 move first value plus two or three, capped.
// - Word items use only the low thirteen bits as length.
// - Fixed count is byte 4 bits 4:0 over byte 5; exact or ceiling.
// - Count is in words for word size, bytes otherwise.
// - Byte 6 bit 7 selects 8-bit (0) or 16-bit (1) items.
// - Byte 6 bits 6:5: single, block, repeated single, repeated block.
// - Trigger 0 is software request only, 1 is previous channel done.
// - Trigger codes 2 to 30 pick peripheral events in ascending order.
// - Byte 7 bits 7:6 step source by 0, 1, 2 or minus one item.
// - Byte 7 bits 5:4 step destination with the same encoding.
// - Completion interrupt only when byte 7 bit 3 is one.
// - Byte lengths use seven bits when byte 7 bit 2 is one.
// - Byte 7 bits 1:0 give channel priority against the processor.
// - Each record is eight consecutive bytes at offsets 0 to 7.
// - Channels one to four share a 32-byte area from channel-one base.
`timescale 1ns/10ps
`default_nettype none
module dcd_top
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Record memory read port
  output logic                         mem_req,
  output logic      [15:0]             mem_addr,
  input  wire logic                    mem_ack,
  input  wire logic [7:0]              mem_rdata,
  // Sequencer side
  output dcd_pkg::dcd_record_t         record,
  output logic                         record_valid,
  output logic signed [3:0]            source_step_bytes,
  output logic signed [3:0]            destination_step_bytes,
  output logic                         block_mode,
  output logic                         repeat_mode,
  output logic                         dma_priority_over_cpu,
  input  wire logic                    first_item_valid,
  input  wire logic [15:0]             first_item,
  output logic      [12:0]             effective_count,
  output logic                         count_valid,
  // Trigger sources and completion
  input  wire logic                    software_channel_request,
  input  wire logic                    previous_channel_done,
  input  wire logic [dcd_pkg::DCD_PERIPH_EVENTS-1:0] peripheral_events,
  output logic                         trigger_fire,
  input  wire logic                    channel_done,
  output logic                         completion_irq
);
  import dcd_pkg::*;

  typedef enum logic [1:0]
  {
    DCD_ST_IDLE  = 2'b00,
    DCD_ST_FETCH = 2'b01,
    DCD_ST_LOAD  = 2'b10
  } dcd_state_t;

  dcd_state_t  state;
  logic [15:0] base0;
  logic [15:0] base1;
  logic [2:0]  chan_sel;
  logic [2:0]  fetched_chan;
  logic [15:0] fetch_base;
  logic [15:0] next_fetch_base;
  logic [2:0]  byte_idx;
  logic [63:0] shift_bytes;
  logic        apb_access;
  logic        apb_write;
  logic        addr_ok;
  logic        start_req;
  logic        start_ok;
  logic [4:0]  periph_index;
  logic        next_trigger;

  // APB decode; every access completes in its first access cycle
  assign apb_access = psel && penable;
  assign apb_write  = apb_access && pwrite;
  assign pready     = 1'b1;

  always_comb
  begin
    case (paddr)
      DCD_CTRL_ADDR, DCD_BASE0_ADDR, DCD_BASE1_ADDR, DCD_STATUS_ADDR,
      DCD_RECLO_ADDR, DCD_RECHI_ADDR, DCD_COUNT_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr   = apb_access && !addr_ok;
  assign start_req = apb_write && paddr == DCD_CTRL_ADDR && pstrb[0]
                     && pwdata[DCD_CTRL_START_BIT];
  // Starts while busy or for a channel above four are dropped silently
  assign start_ok  = start_req && state == DCD_ST_IDLE
                     && pwdata[DCD_CTRL_CHAN_MSB:DCD_CTRL_CHAN_LSB] <= DCD_LAST_CHANNEL;

  always_comb
  begin
    if (pwdata[DCD_CTRL_CHAN_MSB:DCD_CTRL_CHAN_LSB] == 3'h0)
      next_fetch_base = base0;
    else
      next_fetch_base = base1 + {10'h000,
        pwdata[DCD_CTRL_CHAN_MSB:DCD_CTRL_CHAN_LSB] - 3'h1, 3'h0};
  end

  // Base address registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      base0    <= DCD_BASE_RESET;
      base1    <= DCD_BASE_RESET;
      chan_sel <= DCD_CHAN_RESET;
    end
    else if (apb_write)
    begin
      if (paddr == DCD_BASE0_ADDR && pstrb[0])
        base0[7:0] <= pwdata[7:0];
      if (paddr == DCD_BASE0_ADDR && pstrb[1])
        base0[15:8] <= pwdata[15:8];
      if (paddr == DCD_BASE1_ADDR && pstrb[0])
        base1[7:0] <= pwdata[7:0];
      if (paddr == DCD_BASE1_ADDR && pstrb[1])
        base1[15:8] <= pwdata[15:8];
      if (paddr == DCD_CTRL_ADDR && pstrb[0])
        chan_sel <= pwdata[DCD_CTRL_CHAN_MSB:DCD_CTRL_CHAN_LSB];
    end
  end

  // Record fetch: one byte per acknowledged read, offsets 0 to 7
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state        <= DCD_ST_IDLE;
      fetch_base   <= DCD_BASE_RESET;
      fetched_chan <= DCD_CHAN_RESET;
      byte_idx     <= 3'h0;
      shift_bytes  <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      case (state)
        DCD_ST_IDLE:
        begin
          if (start_ok)
          begin
            state        <= DCD_ST_FETCH;
            fetch_base   <= next_fetch_base;
            fetched_chan <= pwdata[DCD_CTRL_CHAN_MSB:DCD_CTRL_CHAN_LSB];
            byte_idx     <= 3'h0;
          end
        end
        DCD_ST_FETCH:
        begin
          if (mem_ack)
          begin
            shift_bytes <= {shift_bytes[55:0], mem_mem_byte(mem_rdata)};
            byte_idx    <= byte_idx + 3'h1;
            if (byte_idx == DCD_LAST_BYTE)
              state <= DCD_ST_LOAD;
          end
        end
        DCD_ST_LOAD:
          state <= DCD_ST_IDLE;
        default:
          state <= DCD_ST_IDLE;
      endcase
    end
  end

  function automatic logic [7:0] mem_mem_byte(input logic [7:0] b);
    mem_mem_byte = b;
  endfunction

  // Reads are held steady until acknowledged; the address wraps at 64 KiB
  assign mem_req  = state == DCD_ST_FETCH;
  assign mem_addr = fetch_base + {13'h0000, byte_idx};

  // Decoded record; bytes land in the struct in memory order
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      record       <= '0;
      record_valid <= 1'b0;
    end
    else if (state == DCD_ST_LOAD)
    begin
      record       <= shift_bytes;
      record_valid <= 1'b1;
    end
    else if (start_ok)
      record_valid <= 1'b0;
  end

  function automatic logic signed [3:0] step_bytes(input logic [1:0] code, input logic word);
    logic signed [3:0] unit;
    unit = 4'sh0;
    case (code)
      DCD_STEP_NONE:  unit = 4'sh0;
      DCD_STEP_ONE:   unit = 4'sh1;
      DCD_STEP_TWO:   unit = 4'sh2;
      DCD_STEP_MINUS: unit = -4'sh1;
      default:        unit = 4'sh0;
    endcase
    step_bytes = word ? unit <<< 1 : unit;
  endfunction

  // Derived controls, registered one cycle behind the record
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      source_step_bytes      <= 4'sh0;
      destination_step_bytes <= 4'sh0;
      block_mode             <= 1'b0;
      repeat_mode            <= 1'b0;
      dma_priority_over_cpu  <= 1'b0;
    end
    else
    begin
      source_step_bytes      <= step_bytes(record.source_step, record.item_width_select);
      destination_step_bytes <= step_bytes(record.destination_step,
                                           record.item_width_select);
      block_mode  <= record.transfer_pattern == DCD_PAT_BLOCK
                     || record.transfer_pattern == DCD_PAT_REPEAT_BLOCK;
      repeat_mode <= record.transfer_pattern == DCD_PAT_REPEAT_SINGLE
                     || record.transfer_pattern == DCD_PAT_REPEAT_BLOCK;
      dma_priority_over_cpu <= record.priority_level[1];
    end
  end

  // Count is in the record's item unit, words or bytes
  dcd_length_calc u_length
  (
    .ref_clk                      (ref_clk),
    .sys_rst                      (sys_rst),
    .first_valid                  (first_item_valid && record_valid),
    .first_item                   (first_item),
    .variable_length_selector     (record.variable_length_selector),
    .fixed_transfer_count         (record.fixed_transfer_count),
    .item_width_select            (record.item_width_select),
    .length_byte_seven_bit_select (record.length_byte_seven_bit_select),
    .effective_count              (effective_count),
    .count_valid                  (count_valid)
  );

  // Trigger selection; code 31 has no source, so only a software request fires it
  assign periph_index = record.trigger_select - DCD_TRIGGER_SELECT_PERIPH_LO;

  always_comb
  begin
    next_trigger = 1'b0;
    if (record.trigger_select == DCD_TRIGGER_SELECT_SOFTWARE)
      next_trigger = software_channel_request;
    else if (record.trigger_select == DCD_TRIGGER_SELECT_PREVIOUS)
      next_trigger = previous_channel_done;
    else if (record.trigger_select <= DCD_TRIGGER_SELECT_PERIPH_HI)
      next_trigger = peripheral_events[periph_index];
  end

  // A software request always starts the channel whatever the trigger
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      trigger_fire <= 1'b0;
    else
      trigger_fire <= record_valid && (next_trigger || software_channel_request);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      completion_irq <= 1'b0;
    else
      completion_irq <= channel_done && record_valid
                        && record.completion_interrupt_enable;
  end

  // APB read data from flip-flops only
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        DCD_CTRL_ADDR:   prdata <= {27'h0000000, chan_sel, 2'h0};
        DCD_BASE0_ADDR:  prdata <= {16'h0000, base0};
        DCD_BASE1_ADDR:  prdata <= {16'h0000, base1};
        DCD_STATUS_ADDR: prdata <= {27'h0000000, fetched_chan, record_valid,
                                    state != DCD_ST_IDLE};
        DCD_RECLO_ADDR:  prdata <= record[63:32];
        DCD_RECHI_ADDR:  prdata <= record[31:0];
        DCD_COUNT_ADDR:  prdata <= {19'h00000, effective_count};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_fetch_address: assert property (mem_req && mem_ack && byte_idx != DCD_LAST_BYTE
      |=> mem_req && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("fetch address did not advance by one");
  a_channel_base: assert property (start_ok && pwdata[4:2] != 3'h0
      |=> fetch_base == $past(base1) + {10'h000, $past(pwdata[4:2]) - 3'h1, 3'h0})
    else $error("channel record base wrong");
  a_eight_bytes: assert property (state == DCD_ST_FETCH && mem_ack && byte_idx == 3'h7
      |=> state == DCD_ST_LOAD ##1 record_valid)
    else $error("record not loaded after eighth byte");
  a_source_bytes: assert property (state == DCD_ST_LOAD
      |=> record.source_pointer == $past(shift_bytes[63:48]))
    else $error("source pointer not from bytes 0 and 1");
  a_step_scale: assert property (record.item_width_select && record.source_step == DCD_STEP_MINUS
      && $stable(record) |=> source_step_bytes == -4'sh2)
    else $error("word step not scaled");
  a_irq_gate: assert property (completion_irq |-> $past(channel_done)
      && $past(record.completion_interrupt_enable))
    else $error("interrupt without enable");
  a_prev_trigger: assert property (record_valid && record.trigger_select == DCD_TRIGGER_SELECT_PREVIOUS
      && previous_channel_done |=> trigger_fire)
    else $error("previous channel trigger missed");
  a_unmapped_err: assert property (apb_access && !addr_ok |-> pslverr && pready)
    else $error("unmapped access not flagged");

  c_record_loaded: cover property (state == DCD_ST_LOAD ##1 record_valid);
  c_irq_raised:    cover property (completion_irq);
  c_periph_fire:   cover property (trigger_fire && record.trigger_select == DCD_TRIGGER_SELECT_PERIPH_HI);

endmodule // dcd_top
`default_nettype wire

// File: dv/dcd_mem_model.sv
// Record memory model: answers byte reads of channel records.
// Assumes the fetcher holds mem_req and mem_addr until each ack.
`timescale 1ns/10ps
`default_nettype none
module dcd_mem_model
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Read port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata,
  // Wait cycles before each ack
  input  wire logic [3:0]  delay
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt;

  // Only the low address byte is decoded, to keep the model small
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 8'hA5;
      cnt       <= 4'h0;
    end
    else if (mem_req && !mem_ack && cnt >= delay)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
      cnt       <= 4'h0;
    end
    else
    begin
      // Between acks the data lines hold nothing, so they toggle
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt       <= mem_req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // dcd_mem_model
`default_nettype wire

// File: dv/dcd_top_tb_top.sv
// Self-checking bench for the channel record decoder.
// Assumes dcd_top and the memory model dcd_mem_model.
`timescale 1ns/10ps
`default_nettype none
module dcd_top_tb_top;
  import dcd_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, delay;
  logic mem_req, mem_ack, record_valid, block_mode, repeat_mode, er;
  logic [15:0] mem_addr, first_item;
  logic [7:0] mem_rdata;
  dcd_record_t record;
  logic signed [3:0] source_step_bytes, destination_step_bytes;
  logic dma_priority_over_cpu, first_item_valid, count_valid, trigger_fire;
  logic [12:0] effective_count;
  logic software_channel_request, previous_channel_done, channel_done, completion_irq;
  logic [DCD_PERIPH_EVENTS-1:0] peripheral_events;
  int err_count = 0;
  int n_tests = 0;

  dcd_top dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .record,
    .record_valid, .source_step_bytes, .destination_step_bytes, .block_mode, .repeat_mode,
    .dma_priority_over_cpu, .first_item_valid, .first_item, .effective_count, .count_valid,
    .software_channel_request, .previous_channel_done, .peripheral_events, .trigger_fire,
    .channel_done, .completion_irq);
  dcd_mem_model u_mem (.ref_clk, .sys_rst, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .delay);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Destination kept in RAM space, never flash; reserved selectors unused
  function automatic logic [63:0] rec(input logic [2:0] s, input logic [12:0] c,
    input logic w, input logic [1:0] p, input logic [4:0] t, input logic [7:0] b7);
    return {16'h1234, 16'h2A5C, s, c, w, p, t, b7};
  endfunction

  task automatic fetch(input logic [2:0] ch, input logic [63:0] r);
    logic [15:0] b;
    b = (ch == 3'h0) ? 16'h0140 : 16'h0178 + {10'h0, ch, 3'h0};
    for (int i = 0; i < 8; i++)
      u_mem.mem[b[7:0] + 8'(i)] = r[63-8*i -: 8];
    apb(1'b1, DCD_CTRL_ADDR, {27'h0, ch, 2'b01});
    repeat (2) @(posedge ref_clk);
    // This wait ends when record_valid rises, or else at the watchdog
    while (record_valid !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    #1;
    chk(record, r);
  endtask

  task automatic t_regs();
    apb(1'b0, DCD_BASE1_ADDR, 32'h0);
    chk(rd, {16'h0, DCD_BASE_RESET});
    apb(1'b1, DCD_BASE0_ADDR, 32'h0140);
    apb(1'b1, DCD_BASE1_ADDR, 32'h0180);
    apb(1'b0, DCD_BASE1_ADDR, 32'h0);
    chk(rd, 32'h0180);
    apb(1'b0, 12'h01C, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    $display("t_regs done");
  endtask

  task automatic t_decode();
    logic [63:0] r;
    delay <= 4'h3;
    r = rec(DCD_VARIABLE_LENGTH_SELECTOR_FIXED, 13'h0011, 1'b1, 2'b01, 5'h00, 8'b1110_1010);
    fetch(3'h0, r);
    chk({60'h0, source_step_bytes, destination_step_bytes}, 64'hE4);
    chk({block_mode, repeat_mode, dma_priority_over_cpu}, 3'b101);
    apb(1'b0, DCD_RECHI_ADDR, 32'h0);
    chk(rd, r[31:0]);
    apb(1'b0, DCD_STATUS_ADDR, 32'h0);
    chk(rd[4:0], 5'b00010);
    delay <= 4'h0;
    r = rec(DCD_VARIABLE_LENGTH_SELECTOR_FIXED_B, 13'h1FFF, 1'b0, 2'b11, 5'h1E, 8'b0100_0100);
    fetch(3'h4, r);
    chk({60'h0, source_step_bytes, destination_step_bytes}, 64'h10);
    chk({block_mode, repeat_mode, dma_priority_over_cpu}, 3'b110);
    apb(1'b0, DCD_RECLO_ADDR, 32'h0);
    chk(rd, r[63:32]);
    apb(1'b0, DCD_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0010);
    $display("t_decode done");
  endtask

  task automatic len_case(input logic [2:0] s, input logic w, input logic m8,
    input logic [15:0] f, input logic [12:0] c, input logic [12:0] e);
    fetch(3'h1, rec(s, c, w, 2'b00, 5'h00, {5'h0, m8, 2'b00}));
    @(posedge ref_clk);
    first_item_valid <= 1'b1;
    first_item       <= f;
    @(posedge ref_clk);
    first_item_valid <= 1'b0;
    #1;
    chk({count_valid, effective_count}, {1'b1, e});
    apb(1'b0, DCD_COUNT_ADDR, 32'h0);
    chk(rd, {19'h0, e});
  endtask

  task automatic t_len();
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_FIXED, 1'b0, 1'b1, 16'h0085, 13'd20, 13'd20);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS1, 1'b0, 1'b1, 16'h0085, 13'd20, 13'd6);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_EXACT, 1'b0, 1'b1, 16'h0085, 13'h1FFF, 13'd5);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS2, 1'b0, 1'b1, 16'h0085, 13'd20, 13'd7);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS3, 1'b0, 1'b1, 16'h0085, 13'd20, 13'd8);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_FIXED_B, 1'b0, 1'b1, 16'h0085, 13'd20, 13'd20);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS1, 1'b0, 1'b0, 16'h0085, 13'd20, 13'd20);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS3, 1'b1, 1'b0, 16'hE00F, 13'd17, 13'd17);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_EXACT, 1'b1, 1'b0, 16'hE00F, 13'd100, 13'd15);
    len_case(DCD_VARIABLE_LENGTH_SELECTOR_PLUS1, 1'b1, 1'b0, 16'hE00F, 13'd100, 13'd16);
    $display("t_len done");
  endtask

  task automatic trigger_select_case(input logic [4:0] t, input logic irq);
    logic [28:0] m;
    m = (t < 5'h02) ? 29'h0 : 29'h1 << (t - 5'h02);
    fetch(3'h2, rec(DCD_VARIABLE_LENGTH_SELECTOR_FIXED, 13'h0004, 1'b0, 2'b10, t, {4'h0, irq, 3'h0}));
    chk({block_mode, repeat_mode}, 2'b01);
    @(posedge ref_clk);
    software_channel_request <= (t == 5'h00);
    previous_channel_done    <= (t == 5'h01);
    peripheral_events        <= m;
    channel_done             <= 1'b1;
    @(posedge ref_clk);
    {software_channel_request, previous_channel_done, channel_done} <= 3'h0;
    peripheral_events <= ~m;
    #1;
    chk({trigger_fire, completion_irq}, {1'b1, irq});
    @(posedge ref_clk);
    peripheral_events <= 29'h0;
    #1;
    chk({trigger_fire, completion_irq}, 2'b00);
  endtask

  task automatic t_trigger_select();
    trigger_select_case(5'h00, 1'b1);
    trigger_select_case(5'h01, 1'b0);
    trigger_select_case(5'h02, 1'b1);
    trigger_select_case(5'h10, 1'b0);
    trigger_select_case(5'h1E, 1'b1);
    $display("t_trigger_select done");
  endtask

  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 12'h0, 32'h0, 4'hF};
    {first_item_valid, first_item, delay} = 21'h0;
    {software_channel_request, previous_channel_done, channel_done} = 3'h0;
    peripheral_events = 29'h0;
    for (int i = 0; i < 256; i++)
      u_mem.mem[i] = 8'(i) ^ 8'h5A;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_decode();
    t_len();
    t_trigger_select();
    conclude();
  end

  // Whole run needs well under 3000 cycles
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end
endmodule // dcd_top_tb_top
`default_nettype wire
